/* File: bench/bofc_output_fault_ctrl_sva.sv */
// Checker for the output fault control ports, bound to the top module
`timescale 1ns/1ps
`default_nettype none
module bofc_output_fault_ctrl_sva (
   input wire logic                  I_SYS_CLK,
   input wire logic                  I_RSTN,
   input wire logic [7:0]            I_AVS_ADDRESS,
   input wire logic                  I_AVS_WRITE,
   input wire logic [31:0]           I_AVS_WRITEDATA,
   input wire logic                  O_AVS_WAITREQUEST,
   input wire logic                  I_CONV_ENABLE,
   input wire bofc_pkg::bofc_sense_t I_SENSE,
   input wire logic                  O_HS_GATE,
   input wire logic                  O_LS_GATE,
   input wire logic                  O_SWITCH_EN,
   input wire logic                  O_CC_REG_EN,
   input wire logic                  O_DISCHARGE_ON,
   input wire logic [1:0]            O_SLEW_SEL
);
   import bofc_pkg::*;
   // ==========================================================
   // Protection, limiter, discharge and slew select relations
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RSTN);
   property p_force;
      O_SWITCH_EN && I_SENSE.hs_over_limit && !I_SENSE.ov_cmp && !I_SENSE.uv_cc_cmp
         && !I_SENSE.uv_cv_cmp |=> !O_HS_GATE && O_LS_GATE;
   endproperty
   a_force: assert property (p_force) else $error("low side not forced");
   property p_hold;
      O_SWITCH_EN && I_SENSE.hs_over_limit ##1 !I_SENSE.ls_below_limit |=> !O_HS_GATE;
   endproperty
   a_hold: assert property (p_hold) else $error("high side on while forced");
   property p_slew;
      I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_ADDRESS == 8'h38
         |-> ##2 O_SLEW_SEL == $past(I_AVS_WRITEDATA[3:2], 2);
   endproperty
   a_slew: assert property (p_slew) else $error("slew select not loaded");
   property p_ov;
      O_SWITCH_EN && I_SENSE.ov_cmp |=> !O_SWITCH_EN;
   endproperty
   a_ov: assert property (p_ov) else $error("over-voltage left switching on");
   property p_latch;
      (O_SWITCH_EN && I_SENSE.ov_cmp) ##1 I_CONV_ENABLE [*4] |-> !O_SWITCH_EN;
   endproperty
   a_latch: assert property (p_latch) else $error("latched converter restarted");
   property p_gates_off;
      !O_SWITCH_EN && !$past(O_SWITCH_EN) |-> !O_HS_GATE && !O_LS_GATE;
   endproperty
   a_gates_off: assert property (p_gates_off) else $error("gate on while stopped");
   property p_dis_rise;
      !O_DISCHARGE_ON && !I_SENSE.vref_down |=> !O_DISCHARGE_ON;
   endproperty
   a_dis_rise: assert property (p_dis_rise) else $error("discharge without step");
   property p_dis_clr;
      O_DISCHARGE_ON && I_SENSE.vout_settled && !I_SENSE.vref_down |=> !O_DISCHARGE_ON;
   endproperty
   a_dis_clr: assert property (p_dis_clr) else $error("discharge held after settle");
   property p_cc_on;
      O_SWITCH_EN && I_SENSE.cc_above_fall ##1 O_SWITCH_EN |-> O_CC_REG_EN;
   endproperty
   a_cc_on: assert property (p_cc_on) else $error("current regulation not enabled");
   // Main scenarios reached
   c_force: cover property (O_SWITCH_EN && I_SENSE.hs_over_limit);
   c_ov: cover property (O_SWITCH_EN && I_SENSE.ov_cmp);
   c_dis: cover property ($rose(O_DISCHARGE_ON));
endmodule
bind bofc_output_fault_ctrl bofc_output_fault_ctrl_sva u_sva (.I_SYS_CLK, .I_RSTN,
   .I_AVS_ADDRESS, .I_AVS_WRITE, .I_AVS_WRITEDATA, .O_AVS_WAITREQUEST, .I_CONV_ENABLE,
   .I_SENSE, .O_HS_GATE, .O_LS_GATE, .O_SWITCH_EN, .O_CC_REG_EN, .O_DISCHARGE_ON, .O_SLEW_SEL);
`default_nettype wire

/* File: bench/bofc_output_fault_ctrl_tb.sv */
// Self-checking bench for the output fault control
`timescale 1ns/1ps
`default_nettype none
module bofc_output_fault_ctrl_tb;
   import bofc_pkg::*;
   localparam int unsigned RW = 20;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic        en = 1'b0;
   bofc_sense_t s = '0;
   logic [31:0] rdata;
   logic        wreq, hs, ls, sw, cc, dis, irq, wq_s;
   logic [1:0]  slew;
   logic [31:0] rd_s;
   int          n_errors = 0;
   int          cmp_count = 0;
   // ==========================================================
   // Clock, design and bus sampling
   always #12.5 clk = ~clk;
   bofc_output_fault_ctrl #(.RETRY_WAIT_CYCLES(RW)) dut (.I_SYS_CLK(clk), .I_RSTN(rstn),
      .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata),
      .I_AVS_BYTEENABLE(4'h1), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq),
      .I_CONV_ENABLE(en), .I_SENSE(s), .O_HS_GATE(hs), .O_LS_GATE(ls), .O_SWITCH_EN(sw),
      .O_CC_REG_EN(cc), .O_DISCHARGE_ON(dis), .O_SLEW_SEL(slew), .O_IRQ(irq));
   // Bus answer as it stands at the coming rising edge
   always @(negedge clk) begin
      wq_s = wreq;
      rd_s = rdata;
   end
   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkb(input logic got, input logic exp);
      chk({31'h0000_0000, got}, {31'h0000_0000, exp});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic look();
      @(negedge clk);
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wq_s !== 1'b0 && n < 50);
      if (n >= 50) n_errors++;
      q = rd_s;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      chk(q, exp);
   endtask
   task automatic wait_sw(input logic v);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (sw !== v && n < 200);
      chkb(sw, v);
   endtask
   task automatic restart();
      tick(1);
      en <= 1'b0;
      tick(2);
      wreg(8'h08, 32'h0000_0070);
      en <= 1'b1;
      wait_sw(1'b1);
   endtask
   task automatic pair();
      tick(1);
      s.hs_over_limit <= 1'b1;
      tick(1);
      s.hs_over_limit <= 1'b0;
      s.ls_below_limit <= 1'b1;
      tick(1);
      s.ls_below_limit <= 1'b0;
   endtask
   task automatic cyc();
      tick(1);
      s.cycle_start <= 1'b1;
      tick(1);
      s.cycle_start <= 1'b0;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_regs();
      logic [7:0] ra[6] = '{8'h08, 8'h0C, 8'h1C, 8'h24, 8'h2C, 8'h38};
      foreach (ra[i]) rdc(ra[i], 32'h0000_0000);
      wreg(8'h3C, 32'h0000_00FF);
      rdc(8'h3C, 32'h0000_0000);
      wreg(8'h25, 32'h0000_00FF);
      rdc(8'h24, 32'h0000_0000);
      $display("test registers done");
   endtask
   task automatic t_slew();
      for (int v = 0; v < 4; v++) begin
         wreg(8'h38, 32'(v) << 2);
         tick(2);
         look();
         chk(32'(slew), 32'(v));
         rdc(8'h38, 32'(v) << 2);
      end
      $display("test slew done");
   endtask
   task automatic t_limit();
      tick(1);
      en <= 1'b1;
      s.reg_hs_cmd <= 1'b1;
      wait_sw(1'b1);
      tick(1);
      s.hs_over_limit <= 1'b1;
      tick(1);
      s.hs_over_limit <= 1'b0;
      look();
      chkb(hs, 1'b0);
      chkb(ls, 1'b1);
      tick(3);
      look();
      chkb(hs, 1'b0);
      tick(1);
      s.ls_below_limit <= 1'b1;
      tick(1);
      s.ls_below_limit <= 1'b0;
      tick(1);
      look();
      chkb(hs, 1'b1);
      pair();
      pair();
      tick(2);
      rdc(8'h0C, 32'h0000_0010);
      cyc();
      cyc();
      repeat (3) pair();
      tick(3);
      look();
      chkb(sw, 1'b1);
      pair();
      wait_sw(1'b0);
      rdc(8'h08, 32'h0000_0040);
      look();
      chkb(irq, 1'b1);
      tick(RW * 3);
      look();
      chkb(sw, 1'b0);
      restart();
      $display("test limiter done");
   endtask
   task automatic t_ov();
      wreg(8'h1C, 32'h0000_0020);
      s.ov_cmp <= 1'b1;
      tick(1);
      s.ov_cmp <= 1'b0;
      wait_sw(1'b0);
      rdc(8'h08, 32'h0000_0020);
      look();
      chkb(irq, 1'b0);
      wreg(8'h1C, 32'h0000_0000);
      tick(2);
      look();
      chkb(irq, 1'b1);
      wreg(8'h08, 32'h0000_0020);
      tick(2);
      look();
      chkb(irq, 1'b0);
      tick(RW * 3);
      look();
      chkb(sw, 1'b0);
      restart();
      $display("test over-voltage done");
   endtask
   task automatic t_uv();
      for (int k = 0; k < 2; k++) begin
         wreg(8'h2C, (k == 1) ? 32'h0000_0008 : 32'h0000_0000);
         s.uv_cc_cmp <= (k == 1);
         s.uv_cv_cmp <= (k == 0);
         tick(4);
         look();
         chkb(sw, 1'b1);
         tick(1);
         s.uv_cc_cmp <= (k == 0);
         s.uv_cv_cmp <= (k == 1);
         wait_sw(1'b0);
         wait_sw(1'b1);
         look();
         chkb(sw, 1'b0);
         tick(1);
         s.uv_cc_cmp <= 1'b0;
         s.uv_cv_cmp <= 1'b0;
         wait_sw(1'b1);
         tick(RW * 2);
         look();
         chkb(sw, 1'b1);
         rdc(8'h08, 32'h0000_0010);
         wreg(8'h08, 32'h0000_0070);
      end
      $display("test under-voltage done");
   endtask
   task automatic t_uv_off();
      wreg(8'h2C, 32'h0000_0000);
      wreg(8'h24, 32'h0000_0008);
      s.cc_above_fall <= 1'b1;
      s.uv_cc_cmp <= 1'b1;
      tick(4);
      look();
      chkb(sw, 1'b1);
      chkb(cc, 1'b1);
      chkb(irq, 1'b1);
      rdc(8'h08, 32'h0000_0010);
      wreg(8'h1C, 32'h0000_0010);
      tick(2);
      look();
      chkb(irq, 1'b0);
      tick(1);
      s.cc_above_fall <= 1'b0;
      s.uv_cc_cmp <= 1'b0;
      tick(2);
      look();
      chkb(cc, 1'b0);
      wreg(8'h1C, 32'h0000_0000);
      wreg(8'h08, 32'h0000_0070);
      wreg(8'h24, 32'h0000_0004);
      s.uv_cc_cmp <= 1'b1;
      wait_sw(1'b0);
      tick(1);
      s.uv_cc_cmp <= 1'b0;
      tick(RW * 3);
      look();
      chkb(sw, 1'b0);
      restart();
      $display("test under-voltage options done");
   endtask
   task automatic t_dis();
      for (int k = 0; k < 2; k++) begin
         wreg(8'h24, (k == 0) ? 32'h0000_0020 : 32'h0000_0000);
         s.vref_down <= 1'b1;
         tick(1);
         s.vref_down <= 1'b0;
         look();
         chkb(dis, k == 0);
         tick(1);
         s.vout_settled <= 1'b1;
         tick(1);
         s.vout_settled <= 1'b0;
         look();
         chkb(dis, 1'b0);
      end
      $display("test discharge done");
   endtask
   // ==========================================================
   // Verdict, watchdog and main sequence
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #500000;
      n_errors++;
      give_verdict();
   end
   initial begin
      tick(10);
      rstn <= 1'b1;
      t_regs();
      t_slew();
      t_limit();
      t_ov();
      t_uv();
      t_uv_off();
      t_dis();
      give_verdict();
   end
endmodule
`default_nettype wire

/* File: rtl/bofc_output_fault_ctrl.sv */
// Main buck output fault control: current limiter, fault flags, hiccup and latch-off
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none


module bofc_output_fault_ctrl #(
   parameter int unsigned RETRY_WAIT_CYCLES = bofc_pkg::RETRY_WAIT_CYC
) (
   input  wire logic                  I_SYS_CLK,
   input  wire logic                  I_RSTN,
   input  wire logic [7:0]            I_AVS_ADDRESS,
   input  wire logic                  I_AVS_READ,
   input  wire logic                  I_AVS_WRITE,
   input  wire logic [31:0]           I_AVS_WRITEDATA,
   input  wire logic [3:0]            I_AVS_BYTEENABLE,
   output logic      [31:0]           O_AVS_READDATA,
   output logic                       O_AVS_WAITREQUEST,
   input  wire logic                  I_CONV_ENABLE,
   input  wire bofc_pkg::bofc_sense_t I_SENSE,
   output logic                       O_HS_GATE,
   output logic                       O_LS_GATE,
   output logic                       O_SWITCH_EN,
   output logic                       O_CC_REG_EN,
   output logic                       O_DISCHARGE_ON,
   output logic      [1:0]            O_SLEW_SEL,
   output logic                       O_IRQ
);
   import bofc_pkg::*;

   // ==========================================================
   // Declarations
   logic [5:0]  reg_idx;
   logic        req;
   logic        wr_acc;
   logic        addr_ok;
   logic [7:0]  rd_byte;
   logic [7:0]  flt_clr;
   logic [7:0]  flt_set;
   logic [7:0]  flt_q;
   logic [7:0]  mask_q;
   logic [7:0]  prot_cfg_q;
   logic [7:0]  conv_opt_q;
   logic [7:0]  edge_cfg_q;
   logic        cc_stat_q;
   logic        hit_q;
   logic [2:0]  pair_cnt_q;
   logic        pair_done;
   logic        oc_evt;
   logic        uv_now;
   logic        uv_act;
   logic        run;
   logic        tmr_start;
   logic        tmr_done;
   bofc_cbc_t   cbc_q;
   bofc_cbc_t   cbc_d;
   bofc_prot_t  ps_q;
   bofc_prot_t  ps_d;

   // ==========================================================
   // Avalon-MM slave: one wait cycle, then answer
   assign req     = I_AVS_READ | I_AVS_WRITE;
   assign reg_idx = I_AVS_ADDRESS[7:2];
   assign addr_ok = (I_AVS_ADDRESS[1:0] == 2'h0);
   assign wr_acc  = I_AVS_WRITE & ~O_AVS_WAITREQUEST & I_AVS_BYTEENABLE[0] & addr_ok;

   // Waitrequest drops for exactly one cycle per request
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_AVS_WAITREQUEST <= 1'b1;
      end else begin
         O_AVS_WAITREQUEST <= ~(req & O_AVS_WAITREQUEST);
      end
   end

   // Read mux; unmapped words read as zero
   always_comb begin
      rd_byte = 8'h00;
      if (addr_ok) begin
         case (reg_idx)
            IDX_FAULT_FLAG: rd_byte = flt_q;
            IDX_REG_STATE:  rd_byte = 8'(cc_stat_q) << ST_CC_BIT;
            IDX_FAULT_MASK: rd_byte = mask_q;
            IDX_PROT_CFG:   rd_byte = prot_cfg_q;
            IDX_CONV_OPT:   rd_byte = conv_opt_q;
            IDX_EDGE_CFG:   rd_byte = edge_cfg_q;
            default:        rd_byte = 8'h00;
         endcase
      end
   end

   // Read data captured in the wait cycle, stands while waitrequest is low
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_AVS_READDATA <= 32'h0000_0000;
      end else if (I_AVS_READ & O_AVS_WAITREQUEST) begin
         O_AVS_READDATA <= {24'h00_0000, rd_byte};
      end
   end

   // Writable configuration registers
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         mask_q     <= RST_MASK;
         prot_cfg_q <= RST_PROT_CFG;
         conv_opt_q <= RST_CONV_OPT;
         edge_cfg_q <= RST_EDGE_CFG;
      end else if (wr_acc) begin
         case (reg_idx)
            IDX_FAULT_MASK: mask_q     <= I_AVS_WRITEDATA[7:0];
            IDX_PROT_CFG:   prot_cfg_q <= I_AVS_WRITEDATA[7:0];
            IDX_CONV_OPT:   conv_opt_q <= I_AVS_WRITEDATA[7:0];
            IDX_EDGE_CFG:   edge_cfg_q <= I_AVS_WRITEDATA[7:0];
            default:        mask_q     <= mask_q;
         endcase
      end
   end

   // ==========================================================
   // Fault flags: write one to clear, a new event wins over the clear
   assign flt_clr = (wr_acc && reg_idx == IDX_FAULT_FLAG) ?
                    (I_AVS_WRITEDATA[7:0] & FLT_ALL_MASK) : 8'h00;

   always_comb begin
      flt_set = 8'h00;
      flt_set[FLT_OC_BIT] = oc_evt;
      flt_set[FLT_OV_BIT] = I_SENSE.ov_cmp;
      flt_set[FLT_UV_BIT] = uv_now;
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         flt_q <= 8'h00;
      end else begin
         flt_q <= (flt_q & ~flt_clr) | flt_set;
      end
   end

   // Interrupt from any unmasked set flag
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_IRQ <= 1'b0;
      end else begin
         O_IRQ <= |(flt_q & ~mask_q & FLT_ALL_MASK);
      end
   end

   // ==========================================================
   // Under-voltage threshold select and action gate
   assign uv_now = conv_opt_q[OPT_UVCV_BIT] ? I_SENSE.uv_cv_cmp
                                            : I_SENSE.uv_cc_cmp;
   assign uv_act = uv_now & ~prot_cfg_q[CFG_UVDIS_BIT];
   assign run    = (ps_q == PS_RUN);

   // ==========================================================
   // Cycle-by-cycle limiter
   always_comb begin
      cbc_d = cbc_q;
      case (cbc_q)
         CBC_FOLLOW: begin
            if (run && I_SENSE.hs_over_limit) begin
               cbc_d = CBC_FORCE;
            end
         end
         CBC_FORCE: begin
            if (!run || I_SENSE.ls_below_limit) begin
               cbc_d = CBC_FOLLOW;
            end
         end
         default: cbc_d = CBC_FOLLOW;
      endcase
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         cbc_q <= CBC_FOLLOW;
      end else begin
         cbc_q <= cbc_d;
      end
   end

   assign pair_done = run && (cbc_q == CBC_FORCE) && I_SENSE.ls_below_limit;
   assign oc_evt    = pair_done && (pair_cnt_q == OC_PAIR_LIMIT - 3'h1);

   // Over-limit seen in the running switching cycle
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         hit_q <= 1'b0;
      end else if (I_SENSE.cycle_start) begin
         hit_q <= I_SENSE.hs_over_limit;
      end else if (I_SENSE.hs_over_limit) begin
         hit_q <= 1'b1;
      end
   end

   // Consecutive pair counter
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         pair_cnt_q <= 3'h0;
      end else if (!run || oc_evt) begin
         pair_cnt_q <= 3'h0;
      end else if (pair_done) begin
         pair_cnt_q <= pair_cnt_q + 3'h1;
      end else if (I_SENSE.cycle_start && !hit_q) begin
         pair_cnt_q <= 3'h0;
      end
   end

   // Constant-current status while the limiter keeps engaging
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         cc_stat_q <= 1'b0;
      end else begin
         cc_stat_q <= (pair_cnt_q >= CC_CONT_PAIRS);
      end
   end

   // Gate drive: limiter overrides the regulation command
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_HS_GATE <= 1'b0;
         O_LS_GATE <= 1'b0;
      end else if (!run) begin
         O_HS_GATE <= 1'b0;
         O_LS_GATE <= 1'b0;
      end else if (cbc_d == CBC_FORCE) begin
         O_HS_GATE <= 1'b0;
         O_LS_GATE <= 1'b1;
      end else begin
         O_HS_GATE <= I_SENSE.reg_hs_cmd;
         O_LS_GATE <= ~I_SENSE.reg_hs_cmd;
      end
   end

   // ==========================================================
   // Protection state machine
   always_comb begin
      ps_d      = ps_q;
      tmr_start = 1'b0;
      case (ps_q)
         PS_OFF: begin
            if (I_CONV_ENABLE) begin
               ps_d = PS_RUN;
            end
         end
         PS_RUN: begin
            if (!I_CONV_ENABLE) begin
               ps_d = PS_OFF;
            end else if (oc_evt || I_SENSE.ov_cmp) begin
               ps_d = PS_LATCH;
            end else if (uv_act && prot_cfg_q[CFG_LATCH_BIT]) begin
               ps_d = PS_LATCH;
            end else if (uv_act) begin
               ps_d      = PS_HICCUP;
               tmr_start = 1'b1;
            end
         end
         PS_HICCUP: begin
            if (!I_CONV_ENABLE) begin
               ps_d = PS_OFF;
            end else if (tmr_done) begin
               ps_d = PS_RUN;
            end
         end
         PS_LATCH: begin
            if (!I_CONV_ENABLE) begin
               ps_d = PS_OFF;
            end
         end
         default: ps_d = PS_OFF;
      endcase
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         ps_q <= PS_OFF;
      end else begin
         ps_q <= ps_d;
      end
   end

   // Retry wait timer
   bofc_retry_timer #(
      .WAIT_CYC (TMR_W'(RETRY_WAIT_CYCLES))
   ) u_retry_timer (
      .i_clk   (I_SYS_CLK),
      .i_rstn  (I_RSTN),
      .i_start (tmr_start),
      .i_abort (~I_CONV_ENABLE),
      .o_done  (tmr_done)
   );

   // Switching enable and CC loop enable
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_SWITCH_EN <= 1'b0;
         O_CC_REG_EN <= 1'b0;
      end else begin
         O_SWITCH_EN <= (ps_d == PS_RUN);
         O_CC_REG_EN <= (ps_d == PS_RUN) && I_SENSE.cc_above_fall;
      end
   end

   // ==========================================================
   // Output discharge on a lowered target
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_DISCHARGE_ON <= 1'b0;
      end else if (!prot_cfg_q[CFG_DIS_BIT] || !I_CONV_ENABLE) begin
         O_DISCHARGE_ON <= 1'b0;
      end else if (I_SENSE.vref_down) begin
         O_DISCHARGE_ON <= 1'b1;
      end else if (I_SENSE.vout_settled) begin
         O_DISCHARGE_ON <= 1'b0;
      end
   end

   // Switch node slew select
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_SLEW_SEL <= 2'h0;
      end else begin
         O_SLEW_SEL <= edge_cfg_q[EDGE_SLEW_LSB +: 2];
      end
   end

endmodule

`default_nettype wire

/* File: rtl/bofc_pkg.sv */
// Package with register map, field layout, states and timing of the output fault control
package bofc_pkg;

   // ==========================================================
   // Clock and timing
   localparam int unsigned CLK_HZ         = 40_000_000;
   localparam int unsigned RETRY_WAIT_US  = 2000;
   localparam int unsigned RETRY_WAIT_CYC = (RETRY_WAIT_US * (CLK_HZ / 1_000_000) > 0) ?
                                            RETRY_WAIT_US * (CLK_HZ / 1_000_000) : 1;
   localparam int unsigned TMR_W          = 20;

   // ==========================================================
   // Register indices (byte address is four times the index)
   localparam logic [5:0] IDX_FAULT_FLAG  = 6'h02;
   localparam logic [5:0] IDX_REG_STATE   = 6'h03;
   localparam logic [5:0] IDX_FAULT_MASK  = 6'h07;
   localparam logic [5:0] IDX_PROT_CFG    = 6'h09;
   localparam logic [5:0] IDX_CONV_OPT    = 6'h0B;
   localparam logic [5:0] IDX_EDGE_CFG    = 6'h0E;

   // ==========================================================
   // Field positions
   localparam int unsigned FLT_OC_BIT     = 6;
   localparam int unsigned FLT_OV_BIT     = 5;
   localparam int unsigned FLT_UV_BIT     = 4;
   localparam int unsigned ST_CC_BIT      = 4;
   localparam int unsigned CFG_DIS_BIT    = 5;
   localparam int unsigned CFG_UVDIS_BIT  = 3;
   localparam int unsigned CFG_LATCH_BIT  = 2;
   localparam int unsigned OPT_UVCV_BIT   = 3;
   localparam int unsigned EDGE_SLEW_LSB  = 2;
   localparam logic [7:0]  FLT_ALL_MASK   = 8'h70;

   // ==========================================================
   // Reset values
   localparam logic [7:0]  RST_MASK       = 8'h00;
   localparam logic [7:0]  RST_PROT_CFG   = 8'h00;
   localparam logic [7:0]  RST_CONV_OPT   = 8'h00;
   localparam logic [7:0]  RST_EDGE_CFG   = 8'h00;

   // ==========================================================
   // Limiter counts
   localparam logic [2:0]  OC_PAIR_LIMIT  = 3'h4;
   localparam logic [2:0]  CC_CONT_PAIRS  = 3'h2;

   // ==========================================================
   // Comparator and control inputs from the analog side
   typedef struct packed {
      logic cycle_start;     // Pulse at start of each switching cycle
      logic reg_hs_cmd;      // Regulation loop asks for high-side on
      logic hs_over_limit;   // High-side current above high_side_current_limit
      logic ls_below_limit;  // Low-side current below low_side_recovery_limit
      logic ov_cmp;          // Output above over-voltage threshold
      logic uv_cc_cmp;       // Output below constant-current under-voltage threshold
      logic uv_cv_cmp;       // Output below constant-voltage under-voltage threshold
      logic cc_above_fall;   // Output above the CC falling disable threshold
      logic vref_down;       // Pulse when the output target is lowered
      logic vout_settled;    // Output has reached its target
   } bofc_sense_t;

   // Limiter states
   typedef enum logic [1:0] {
      CBC_FOLLOW = 2'b01,
      CBC_FORCE  = 2'b10
   } bofc_cbc_t;

   // Converter protection states
   typedef enum logic [3:0] {
      PS_OFF    = 4'b0001,
      PS_RUN    = 4'b0010,
      PS_HICCUP = 4'b0100,
      PS_LATCH  = 4'b1000
   } bofc_prot_t;

endpackage

/* File: rtl/bofc_retry_timer.sv */
// Retry wait timer for the hiccup loop
`timescale 1ns/1ps
`default_nettype none

module bofc_retry_timer #(
   parameter logic [bofc_pkg::TMR_W-1:0] WAIT_CYC = bofc_pkg::TMR_W'(bofc_pkg::RETRY_WAIT_CYC)
) (
   input  wire logic i_clk,
   input  wire logic i_rstn,
   input  wire logic i_start,
   input  wire logic i_abort,
   output logic      o_done
);
   import bofc_pkg::*;

   logic [TMR_W-1:0] cnt_q;
   logic             busy_q;

   // ==========================================================
   // Count down from the wait length; done pulses on expiry
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_q  <= '0;
         busy_q <= 1'b0;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_abort) begin
            busy_q <= 1'b0;
         end else if (i_start) begin
            cnt_q  <= WAIT_CYC - TMR_W'(1);
            busy_q <= 1'b1;
         end else if (busy_q) begin
            if (cnt_q == '0) begin
               busy_q <= 1'b0;
               o_done <= 1'b1;
            end else begin
               cnt_q <= cnt_q - TMR_W'(1);
            end
         end
      end
   end

endmodule

`default_nettype wire
